// File: verilog/burst_sram_pkg.sv
package burst_sram_pkg;

  // array geometry: 2M words of four byte lanes, each lane 8 data bits plus parity
  localparam int ADDR_W = 21;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DEPTH = 2097152;

  // two low address bits are walked by the burst counter
  localparam int BURST_BITS = 2;
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_STEP = 2'h1;

  // sleep entry and exit, in clock cycles, paced by the sleep synchroniser depth
  localparam int SLEEP_CYCLES = 2;

  // mode strap levels
  localparam logic MODE_LINEAR = 1'b0;
  localparam logic MODE_INTERLEAVED = 1'b1;

  // one access travelling down the pipeline
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes_n;
  } stage_t;

  localparam stage_t STAGE_IDLE = '0;

endpackage : burst_sram_pkg

// File: verilog/burst_address_gen.sv
`timescale 1ns/1ps

module burst_address_gen
  import burst_sram_pkg::*;
(
  // burst start and beat
  input wire logic [BURST_BITS-1:0] start_i,
  input wire logic [BURST_BITS-1:0] beat_i,
  input wire logic interleaved_i,
  // low address bits for this beat
  output logic [BURST_BITS-1:0] addr_bits_o
);

  // both orders wrap inside the four-word group by construction
  always_comb begin
    if (interleaved_i) begin
      addr_bits_o = start_i ^ beat_i;
    end else begin
      addr_bits_o = BURST_BITS'(start_i + beat_i);
    end
  end

endmodule : burst_address_gen

// File: verilog/sram_byte_array.sv
`timescale 1ns/1ps

module sram_byte_array
  import burst_sram_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [LANES-1:0] wr_parity_i,
  input wire logic [LANES-1:0] wr_lanes_n_i,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic [LANES-1:0] rd_parity_o
);

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      logic [LANE_W-1:0] mem [DEPTH];
      // unselected lanes keep their old contents
      always_ff @(posedge mclk_i) begin
        if (wr_en_i && !wr_lanes_n_i[g]) begin
          mem[wr_addr_i] <= {wr_parity_i[g], wr_data_i[8*g +: 8]};
        end
      end
      assign rd_data_o[8*g +: 8] = mem[rd_addr_i][7:0];
      assign rd_parity_o[g] = mem[rd_addr_i][8];
    end
  endgenerate

endmodule : sram_byte_array

// File: verilog/pipelined_burst_sram_control.sv
`timescale 1ns/1ps

module pipelined_burst_sram_control
  import burst_sram_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // command pins
  input wire logic clock_qualify_n_i,
  input wire logic chip_select_first_n_i,
  input wire logic chip_select_second_i,
  input wire logic chip_select_third_n_i,
  input wire logic write_strobe_n_i,
  input wire logic advance_or_load_i,
  input wire logic [LANES-1:0] byte_lane_write_n_i,
  input wire logic [ADDR_W-1:0] address_i,
  // asynchronous and strap pins
  input wire logic output_drive_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_mode_i,
  // data and parity bus
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [LANES-1:0] parity_i,
  output logic [LANES-1:0] parity_o,
  output logic parity_oe_o,
  // status
  output logic sleeping_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    stage_t s1;
    stage_t s2;
    logic [ADDR_W-1:0] burst_base;
    logic [BURST_BITS-1:0] beat;
    logic burst_write;
    logic burst_live;
    logic burst_ilv;
    logic [1:0] oe_sync;
    logic [SLEEP_CYCLES-1:0] sleep_sync;
    logic [1:0] mode_sync;
    logic read_active;
    logic drive;
    logic [DATA_W-1:0] q_data;
    logic [LANES-1:0] q_parity;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic selected;
  logic asleep;
  logic qualified;
  logic [BURST_BITS-1:0] beat_bits;
  logic [BURST_BITS-1:0] next_beat;
  logic mem_wr_en;
  logic [DATA_W-1:0] rd_data;
  logic [LANES-1:0] rd_parity;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode

  assign selected = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
  assign asleep = st.sleep_sync[SLEEP_CYCLES-1];
  assign qualified = !clock_qualify_n_i && !asleep;
  assign next_beat = BURST_BITS'(st.beat + BEAT_STEP);
  assign mem_wr_en = qualified && st.s2.valid && st.s2.write;

  burst_address_gen u_burst_address_gen (
    .start_i(st.burst_base[BURST_BITS-1:0]),
    .beat_i(next_beat),
    .interleaved_i(st.burst_ilv),
    .addr_bits_o(beat_bits)
  );

  // write data is sampled straight into the array: the array write is its input register
  sram_byte_array u_sram_byte_array (
    .mclk_i(mclk_i),
    .wr_en_i(mem_wr_en),
    .wr_addr_i(st.s2.addr),
    .wr_data_i(data_i),
    .wr_parity_i(parity_i),
    .wr_lanes_n_i(st.s2.lanes_n),
    .rd_addr_i(st.s1.addr),
    .rd_data_o(rd_data),
    .rd_parity_o(rd_parity)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // asynchronous pins pass two flops; these run even on ignored edges
    next_st.oe_sync = {st.oe_sync[0], output_drive_n_i};
    next_st.sleep_sync = {st.sleep_sync[0], sleep_request_i};
    next_st.mode_sync = {st.mode_sync[0], burst_mode_i};
    if (asleep) begin
      // pending work is dropped; the array contents are untouched
      next_st.s1 = STAGE_IDLE;
      next_st.s2 = STAGE_IDLE;
      next_st.burst_live = 1'b0;
      next_st.read_active = 1'b0;
    end else if (qualified) begin
      next_st.s2 = st.s1;
      next_st.s1 = STAGE_IDLE;
      if (!advance_or_load_i) begin
        if (selected) begin
          next_st.s1.valid = 1'b1;
          next_st.s1.write = !write_strobe_n_i;
          next_st.s1.addr = address_i;
          next_st.s1.lanes_n = byte_lane_write_n_i;
          next_st.burst_base = address_i;
          next_st.beat = BEAT_FIRST;
          next_st.burst_write = !write_strobe_n_i;
          next_st.burst_live = 1'b1;
          next_st.burst_ilv = (st.mode_sync[1] == MODE_INTERLEAVED);
        end else begin
          // a deselect ends the burst; only a fresh load restarts it
          next_st.burst_live = 1'b0;
        end
      end else if (st.burst_live) begin
        // selects and strobe are ignored on a continuation edge
        next_st.beat = next_beat;
        next_st.s1.valid = 1'b1;
        next_st.s1.write = st.burst_write;
        next_st.s1.addr = {st.burst_base[ADDR_W-1:BURST_BITS], beat_bits};
        next_st.s1.lanes_n = byte_lane_write_n_i;
      end
      // a write in s1 floats the bus on this edge, whatever the output enable
      next_st.read_active = st.s1.valid && !st.s1.write;
      if (st.s1.valid && !st.s1.write) begin
        next_st.q_data = rd_data;
        next_st.q_parity = rd_parity;
      end
    end
    // output enable acts through its synchroniser and the drive flop, so it lags the pin by three cycles
    next_st.drive = next_st.read_active && !st.oe_sync[1] && !asleep;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign data_o = st.q_data;
  assign parity_o = st.q_parity;
  assign data_oe_o = st.drive;
  assign parity_oe_o = st.drive;
  assign sleeping_o = st.sleep_sync[SLEEP_CYCLES-1];

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic read_cmd;
  logic write_cmd;
  logic desel_cmd;
  logic cont_cmd;

  assign read_cmd = qualified && !advance_or_load_i && selected && write_strobe_n_i;
  assign write_cmd = qualified && !advance_or_load_i && selected && !write_strobe_n_i;
  assign desel_cmd = qualified && !advance_or_load_i && !selected;
  assign cont_cmd = qualified && advance_or_load_i && st.burst_live;

  property p_ignored_edge_holds;
    @(posedge mclk_i) disable iff (reset_i)
      clock_qualify_n_i |=> $stable(st.s1) && $stable(st.s2) && $stable(st.beat) && $stable(data_o);
  endproperty
  a_ignored_edge_holds: assert property (p_ignored_edge_holds)
    else $error("ignored edge changed state");

  property p_read_load;
    @(posedge mclk_i) disable iff (reset_i)
      read_cmd |=> st.s1.valid && !st.s1.write && st.s1.addr == $past(address_i);
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read command not loaded");

  property p_read_data_next_edge;
    @(posedge mclk_i) disable iff (reset_i)
      (qualified && st.s1.valid && !st.s1.write) |=> data_o == $past(rd_data) && st.read_active;
  endproperty
  a_read_data_next_edge: assert property (p_read_data_next_edge)
    else $error("read data not registered on next edge");

  property p_drive_follows_enable;
    @(posedge mclk_i) disable iff (reset_i)
      st.oe_sync[1] |=> !data_oe_o && !parity_oe_o;
  endproperty
  a_drive_follows_enable: assert property (p_drive_follows_enable)
    else $error("bus driven while output enable high");

  property p_back_to_back;
    @(posedge mclk_i) disable iff (reset_i)
      read_cmd ##1 write_cmd |=> st.s1.valid && st.s1.write && st.s2.valid && !st.s2.write;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("command after read not accepted");

  property p_deselect_pipelined;
    @(posedge mclk_i) disable iff (reset_i)
      desel_cmd ##1 qualified |=> !data_oe_o;
  endproperty
  a_deselect_pipelined: assert property (p_deselect_pipelined)
    else $error("outputs still driven after deselect");

  property p_no_continue_after_deselect;
    @(posedge mclk_i) disable iff (reset_i)
      desel_cmd ##1 (qualified && advance_or_load_i) |=> !st.s1.valid;
  endproperty
  a_no_continue_after_deselect: assert property (p_no_continue_after_deselect)
    else $error("burst continued from deselect");

  property p_upper_bits_fixed;
    @(posedge mclk_i) disable iff (reset_i)
      cont_cmd |=> st.s1.addr[ADDR_W-1:BURST_BITS] == $past(st.burst_base[ADDR_W-1:BURST_BITS]);
  endproperty
  a_upper_bits_fixed: assert property (p_upper_bits_fixed)
    else $error("burst changed upper address bits");

  property p_burst_order;
    @(posedge mclk_i) disable iff (reset_i)
      cont_cmd |=> st.s1.addr[1:0] == ($past(st.burst_ilv)
        ? ($past(st.burst_base[1:0]) ^ $past(next_beat))
        : 2'($past(st.burst_base[1:0]) + $past(next_beat)));
  endproperty
  a_burst_order: assert property (p_burst_order)
    else $error("wrong burst address order");

  property p_continuation_ignores_selects;
    @(posedge mclk_i) disable iff (reset_i)
      cont_cmd |=> st.s1.valid && st.s1.write == $past(st.burst_write);
  endproperty
  a_continuation_ignores_selects: assert property (p_continuation_ignores_selects)
    else $error("continuation dropped or changed direction");

  property p_write_floats_bus;
    @(posedge mclk_i) disable iff (reset_i)
      write_cmd ##1 qualified |=> !data_oe_o && !parity_oe_o;
  endproperty
  a_write_floats_bus: assert property (p_write_floats_bus)
    else $error("bus driven during write");

  property p_write_second_edge;
    @(posedge mclk_i) disable iff (reset_i)
      write_cmd ##1 qualified ##1 qualified |-> mem_wr_en && st.s2.addr == $past(address_i, 2);
  endproperty
  a_write_second_edge: assert property (p_write_second_edge)
    else $error("write data not taken at second edge");

  property p_sleep_entry;
    @(posedge mclk_i) disable iff (reset_i)
      sleep_request_i [*3] |-> sleeping_o && !data_oe_o && !st.s1.valid;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered within two cycles");

  property p_write_load;
    @(posedge mclk_i) disable iff (reset_i)
      write_cmd |=> st.s1.valid && st.s1.write && st.s1.addr == $past(address_i)
        && st.s1.lanes_n == $past(byte_lane_write_n_i);
  endproperty
  a_write_load: assert property (p_write_load)
    else $error("write command not loaded");

  property p_write_then_read;
    @(posedge mclk_i) disable iff (reset_i)
      write_cmd ##1 read_cmd |=> st.s1.valid && !st.s1.write && st.s2.valid && st.s2.write;
  endproperty
  a_write_then_read: assert property (p_write_then_read)
    else $error("read after write not accepted");

  property p_counter_steps;
    @(posedge mclk_i) disable iff (reset_i)
      cont_cmd |=> st.beat == BURST_BITS'($past(st.beat) + BEAT_STEP);
  endproperty
  a_counter_steps: assert property (p_counter_steps)
    else $error("burst counter did not step");

  property p_mode_at_load;
    @(posedge mclk_i) disable iff (reset_i)
      (qualified && !advance_or_load_i && selected)
        |=> st.burst_ilv == ($past(st.mode_sync[1]) == MODE_INTERLEAVED);
  endproperty
  a_mode_at_load: assert property (p_mode_at_load)
    else $error("burst order not taken from strap at load");

  property p_direction_at_load;
    @(posedge mclk_i) disable iff (reset_i)
      (qualified && !advance_or_load_i && selected)
        |=> st.burst_live && st.burst_write == !$past(write_strobe_n_i);
  endproperty
  a_direction_at_load: assert property (p_direction_at_load)
    else $error("burst direction not latched at load");

  property p_selects_off_continue;
    @(posedge mclk_i) disable iff (reset_i)
      (cont_cmd && !selected) |=> st.s1.valid;
  endproperty
  a_selects_off_continue: assert property (p_selects_off_continue)
    else $error("continuation blocked by inactive selects");

  property p_sleep_clears;
    @(posedge mclk_i) disable iff (reset_i)
      asleep |=> !data_oe_o && !parity_oe_o && !st.s1.valid && !st.s2.valid && !st.burst_live;
  endproperty
  a_sleep_clears: assert property (p_sleep_clears)
    else $error("activity while asleep");

  property p_sleep_exit;
    @(posedge mclk_i) disable iff (reset_i)
      !sleep_request_i ##1 !sleep_request_i |=> !sleeping_o;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit)
    else $error("sleep not left within two cycles");

endmodule : pipelined_burst_sram_control

// File: tb/mem_ctrl_model.sv
`timescale 1ns/1ps

module mem_ctrl_model
  import burst_sram_pkg::*;
(
  // clock and device drive
  input wire logic mclk_i,
  input wire logic [DATA_W-1:0] dev_data_i,
  input wire logic [LANES-1:0] dev_par_i,
  input wire logic dev_oe_i,
  // command pins
  output logic qual_n_o,
  output logic [2:0] sel_o,
  output logic we_n_o,
  output logic adv_o,
  output logic [LANES-1:0] lanes_n_o,
  output logic [ADDR_W-1:0] addr_o,
  // resolved bus
  output logic [DATA_W-1:0] bus_data_o,
  output logic [LANES-1:0] bus_par_o,
  output logic driving_o
);
  logic [36:0] next_beat, stage1, stage2;
  logic [35:0] last_bus;
  logic [1:0] dsel;

  initial begin
    {qual_n_o, we_n_o, adv_o, dsel} = '0;
    sel_o = 3'b101;
    lanes_n_o = 4'hf;
    addr_o = '0;
    {next_beat, stage1, stage2, last_bus} = '0;
  end

  ////////////////////////////////////////
  // write data rides two qualified edges behind its beat
  always @(posedge mclk_i) begin
    if (!qual_n_o) begin
      stage2 <= stage1;
      stage1 <= next_beat;
    end
    last_bus <= {bus_par_o, bus_data_o};
  end

  // a released bus shows the inverse of its last level, never a stale copy
  always_comb begin
    driving_o = stage2[36];
    if (dev_oe_i)
      {bus_par_o, bus_data_o} = {dev_par_i, dev_data_i};
    else if (driving_o)
      {bus_par_o, bus_data_o} = stage2[35:0];
    else
      {bus_par_o, bus_data_o} = ~last_bus;
  end

  ////////////////////////////////////////
  // kind: 0 deselect, 1 read, 2 write, 3 continue
  task automatic beat(input logic [1:0] kind, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
                      input logic wr, input logic [35:0] wd);
    @(posedge mclk_i);
    #1;
    qual_n_o = 1'b0;
    adv_o = (kind == 2'd3);
    // deselects rotate which select is off; continuations look deselected on purpose
    sel_o = (kind == 2'd0) ? 3'b010 ^ (3'b001 << dsel) : (kind == 2'd3) ? 3'b101 : 3'b010;
    we_n_o = (kind == 2'd3) ? wr : (kind != 2'd2);
    dsel = (kind != 2'd0) ? dsel : (dsel == 2'd2) ? 2'd0 : dsel + 2'd1;
    lanes_n_o = ln;
    addr_o = a;
    next_beat = {wr, wd};
  endtask : beat

  task automatic stall(input int n);
    @(posedge mclk_i);
    #1;
    qual_n_o = 1'b1;
    repeat (n - 1) @(posedge mclk_i);
  endtask : stall
endmodule : mem_ctrl_model

// File: tb/testbench.sv
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module testbench
  import burst_sram_pkg::*;
;
  logic mclk, reset, drive_n, sleep, mode, qual_n, we_n, adv, driving;
  logic data_oe, par_oe, sleeping;
  logic [2:0] sel;
  logic [LANES-1:0] lanes_n, bus_par, rd_par;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] bus_data, rd_data;
  int num_errors = 0;
  int checks_done = 0;
  int seed;
  logic [35:0] mem [int];
  logic [35:0] expq [$];

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  pipelined_burst_sram_control i_dut (
    .mclk_i(mclk), .reset_i(reset), .clock_qualify_n_i(qual_n),
    .chip_select_first_n_i(sel[2]), .chip_select_second_i(sel[1]), .chip_select_third_n_i(sel[0]),
    .write_strobe_n_i(we_n), .advance_or_load_i(adv), .byte_lane_write_n_i(lanes_n), .address_i(addr),
    .output_drive_n_i(drive_n), .sleep_request_i(sleep), .burst_mode_i(mode),
    .data_i(bus_data), .data_o(rd_data), .data_oe_o(data_oe),
    .parity_i(bus_par), .parity_o(rd_par), .parity_oe_o(par_oe), .sleeping_o(sleeping)
  );

  mem_ctrl_model i_ctrl (
    .mclk_i(mclk), .dev_data_i(rd_data), .dev_par_i(rd_par), .dev_oe_i(data_oe),
    .qual_n_o(qual_n), .sel_o(sel), .we_n_o(we_n), .adv_o(adv), .lanes_n_o(lanes_n), .addr_o(addr),
    .bus_data_o(bus_data), .bus_par_o(bus_par), .driving_o(driving)
  );

  ////////////////////////////////////////
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n, input logic [3:0] ln);
    for (int g = 0; g < LANES; g++) begin
      if (!ln[g]) begin
        o[8*g +: 8] = n[8*g +: 8];
        o[32 + g] = n[32 + g];
      end
    end
    return o;
  endfunction : merge

  task automatic idle(input int n);
    repeat (n) i_ctrl.beat(2'd0, '0, 4'hf, 1'b0, '0);
  endtask : idle

  // reads note their expectation at issue, so program order settles any overlap
  task automatic burst(input logic wr, input logic [ADDR_W-1:0] a, input int n, input int st, input logic full);
    logic [ADDR_W-1:0] ad;
    logic [35:0] d;
    logic [3:0] ln;
    for (int k = 0; k < n; k++) begin
      ad = a;
      ad[1:0] = mode ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
      d = 36'({$random(seed), $random(seed)});
      ln = full ? 4'h0 : 4'($random(seed));
      if (wr)
        mem[ad] = merge(mem.exists(ad) ? mem[ad] : '0, d, ln);
      else if (!drive_n)
        expq.push_back(mem[ad]);
      i_ctrl.beat(k == 0 ? (wr ? 2'd2 : 2'd1) : 2'd3, a, ln, wr, d);
      if (k == st)
        i_ctrl.stall(2);
    end
  endtask : burst

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  ////////////////////////////////////////
  // results are taken only on qualified edges, so a stall never pops twice
  always @(posedge mclk) begin : watch
    logic q;
    logic [35:0] e;
    q = qual_n;
    #2;
    `CHK(par_oe, data_oe)
    if (driving)
      `CHK(data_oe, 1'b0)
    if (!q && data_oe === 1'b1) begin
      if (expq.size() == 0)
        `CHK(data_oe, 1'b0)
      else begin
        e = expq.pop_front();
        `CHK({rd_par, rd_data}, e)
      end
    end
  end

  initial begin : main
    logic [ADDR_W-1:0] base;
    seed = 32'hbea0_ecfc;
    {reset, drive_n, sleep, mode} = 4'b1000;
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      idle(3);
      base = ADDR_W'($random(seed));
      burst(1'b1, base, 4, m, 1'b1);
      burst(1'b0, base, 5, 2, 1'b0);
      idle(2);
      burst(1'b1, base, 1, -1, 1'b0);
      idle(2);
      burst(1'b0, base, 4, 3, 1'b0);
      burst(1'b0, base, 1, -1, 1'b0);
      burst(1'b1, base ^ 21'h4, 2, -1, 1'b1);
      burst(1'b1, base ^ 21'h8, 1, -1, 1'b1);
      burst(1'b0, base ^ 21'h4, 1, -1, 1'b0);
    end
    drive_n = 1'b1;
    idle(3);
    burst(1'b0, base, 2, -1, 1'b0);
    idle(1);
    i_ctrl.beat(2'd3, base, 4'hf, 1'b0, '0);
    idle(3);
    drive_n = 1'b0;
    idle(3);
    sleep = 1'b1;
    @(posedge mclk);
    #1 `CHK(sleeping, 1'b0)
    @(posedge mclk);
    #1 `CHK(sleeping, 1'b1)
    idle(4);
    sleep = 1'b0;
    @(posedge mclk);
    #1 `CHK(sleeping, 1'b1)
    @(posedge mclk);
    #1 `CHK(sleeping, 1'b0)
    idle(3);
    burst(1'b0, base ^ 21'h4, 2, -1, 1'b0);
    idle(3);
    `CHK(expq.size(), 0)
    results();
  end

  // a hang counts as a mismatch
  initial begin
    #100_000;
    num_errors++;
    results();
  end
endmodule : testbench
